//--- inc/sgq_pkg.sv
/*
  Package for the two status-reporting groups: the baseband generator
  group and the doubtful-data group.
  Holds register indices, bit positions, reset values and the request
  carrier. Assumes a single 25 MHz clock domain in the using module.
*/
package sgq_pkg;

  // register word width
  localparam int unsigned REG_W = 16;
  localparam int unsigned SEL_W = 4;

  // register indices on the command port
  localparam logic [3:0] IDX_IQ_GEN_CONDITION = 4'h0;
  localparam logic [3:0] IDX_IQ_GEN_RISING_FILTER = 4'h1;
  localparam logic [3:0] IDX_IQ_GEN_FALLING_FILTER = 4'h2;
  localparam logic [3:0] IDX_IQ_GEN_EVENT_LATCH = 4'h3;
  localparam logic [3:0] IDX_IQ_GEN_SUMMARY_MASK = 4'h4;
  localparam logic [3:0] IDX_DOUBTFUL_DATA_CONDITION = 4'h5;
  localparam logic [3:0] IDX_DOUBTFUL_DATA_RISING_FILTER = 4'h6;
  localparam logic [3:0] IDX_DOUBTFUL_DATA_FALLING_FILTER = 4'h7;
  localparam logic [3:0] IDX_DOUBTFUL_DATA_EVENT_LATCH = 4'h8;
  localparam logic [3:0] IDX_DOUBTFUL_DATA_SUMMARY_MASK = 4'h9;

  // baseband condition bit positions
  localparam int unsigned BB_BUSY_BIT = 0;
  localparam int unsigned BB_COMM_BIT = 1;

  // doubtful-data condition bit positions
  localparam int unsigned DQ_POWER_BIT = 3;
  localparam int unsigned DQ_OVEN_COLD_BIT = 4;
  localparam int unsigned DQ_FREQ_BIT = 5;
  localparam int unsigned DQ_MOD_BIT = 7;
  localparam int unsigned DQ_CAL_BIT = 8;
  localparam int unsigned DQ_SELF_TEST_BIT = 9;

  // values after reset
  localparam logic [15:0] RISING_FILTER_RST = 16'hFFFF;
  localparam logic [15:0] FALLING_FILTER_RST = 16'h0000;
  localparam logic [15:0] SUMMARY_MASK_RST = 16'h0000;
  localparam logic [15:0] EVENT_LATCH_RST = 16'h0000;
  localparam logic [15:0] CONDITION_RST = 16'h0000;
  localparam logic [15:0] READ_DATA_RST = 16'h0000;

  // number of live status inputs, all passed through synchronisers
  localparam int unsigned NUM_STATUS_IN = 8;

  // one register command: read or write of one indexed register
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] sel;
    logic [15:0] data;
  } sgq_req_t;

endpackage

//--- hw/sgq_status_groups.sv
/*
  Status register bank for the baseband generator group and the
  doubtful-data group: live condition registers, rising and falling
  transition filters, latching event registers that clear on read, and
  enable masks that gate each group onto one summary output.
  Assumes status inputs arrive asynchronously from other hardware, the
  command port is driven from logic on i_ref_clk, and the summary outputs
  are collected by the operation group and the status byte elsewhere.
*/
// Functional notes
// - condition bit 0 of the baseband group shows the generator is active
// - condition bit 1 of the baseband group shows data input or output
// - baseband condition bits 2 to 15 always read zero
// - condition registers follow live status, are read-only, ignore writes
// - reads return the binary word, whose value is the sum of weights
// - rising filter selects 0 to 1, falling filter 1 to 0 changes
// - event bits latch selected transitions and hold until cleared
// - reading an event register returns it and clears all its bits
// - baseband mask selects events driving operation-group bit 10 summary
// - doubtful mask selects events driving status-byte bit 3 summary
// - doubtful bit 3 carries the power sub-group summary
// - doubtful bit 4 is set while the reference oven is cold
// - doubtful bit 5 carries the frequency sub-group summary
// - doubtful bit 7 carries the modulation sub-group summary
// - doubtful bit 8 carries the calibration sub-group summary
// - doubtful bit 9 flags self-test failure, cleared only by power cycle
// - doubtful bits 0,1,2,6,10 to 15 always read zero
// - filter and mask writes load the written sum as the bit mask
// - a mask query returns the value most recently written
`timescale 1ns/100ps
`default_nettype none

module sgq_status_groups (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // live status from the generator and sub-groups
  input wire logic i_bb_busy,
  input wire logic i_bb_comm,
  input wire logic i_power_summary,
  input wire logic i_oven_cold,
  input wire logic i_freq_summary,
  input wire logic i_mod_summary,
  input wire logic i_cal_summary,
  input wire logic i_self_test_fail,
  // clear-status command, one-cycle pulse
  input wire logic i_clear_status,
  // register command port
  input wire sgq_pkg::sgq_req_t i_req,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  // summary outputs
  output logic o_oper_bb_summary,
  output logic o_stb_doubtful_summary
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // selected transitions of a condition word
  function automatic logic [15:0] sgq_edges(input logic [15:0] cur, input logic [15:0] prev,
                                             input logic [15:0] rise_f, input logic [15:0] fall_f);
    sgq_edges = (cur & ~prev & rise_f) | (~cur & prev & fall_f);
  endfunction

  // any enabled event bit
  function automatic logic sgq_summary(input logic [15:0] ev, input logic [15:0] mask);
    sgq_summary = |(ev & mask);
  endfunction

  // one strobe aimed at one register index
  function automatic logic sgq_hit(input logic strobe, input logic [3:0] sel, input logic [3:0] idx);
    sgq_hit = strobe && (sel == idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: three stages, a change counts once stages two
  // and three agree, so a single metastable sample never reaches logic

  logic [sgq_pkg::NUM_STATUS_IN-1:0] raw_in;
  logic [sgq_pkg::NUM_STATUS_IN-1:0] sync_1;
  logic [sgq_pkg::NUM_STATUS_IN-1:0] sync_2;
  logic [sgq_pkg::NUM_STATUS_IN-1:0] sync_3;
  logic [sgq_pkg::NUM_STATUS_IN-1:0] stable_in;

  assign raw_in = {i_self_test_fail, i_cal_summary, i_mod_summary, i_freq_summary,
                   i_oven_cold, i_power_summary, i_bb_comm, i_bb_busy};

  // stages reset to the idle level of the pins, so no false
  // transition is seen in the first cycles after reset
  // shift chain
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sync_1 <= '0;
      sync_2 <= '0;
      sync_3 <= '0;
    end else begin
      sync_1 <= raw_in;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
    end
  end

  // agreement filter, bit by bit
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      stable_in <= '0;
    end else begin
      for (int i = 0; i < sgq_pkg::NUM_STATUS_IN; i++) begin
        if (sync_2[i] == sync_3[i]) begin
          stable_in[i] <= sync_3[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-test failure is sticky; only reset (power cycle) clears it,
  // clear-status deliberately has no path here

  logic self_test_failed;

  // a pin pulse must survive two agreeing samples before it sticks
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      self_test_failed <= 1'h0;
    end else if (stable_in[7]) begin
      self_test_failed <= 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // condition words, rebuilt every cycle from live status; no write
  // path exists, so writes cannot reach them

  logic [15:0] bb_cond;
  logic [15:0] dq_cond;

  always_comb begin
    bb_cond = 16'h0000;
    bb_cond[sgq_pkg::BB_BUSY_BIT] = stable_in[0];
    bb_cond[sgq_pkg::BB_COMM_BIT] = stable_in[1];
  end

  // bit 9 follows the sticky flag rather than the pin, so clear-status cannot drop it
  always_comb begin
    dq_cond = 16'h0000;
    dq_cond[sgq_pkg::DQ_POWER_BIT] = stable_in[2];
    dq_cond[sgq_pkg::DQ_OVEN_COLD_BIT] = stable_in[3];
    dq_cond[sgq_pkg::DQ_FREQ_BIT] = stable_in[4];
    dq_cond[sgq_pkg::DQ_MOD_BIT] = stable_in[5];
    dq_cond[sgq_pkg::DQ_CAL_BIT] = stable_in[6];
    dq_cond[sgq_pkg::DQ_SELF_TEST_BIT] = self_test_failed;
  end

  // previous condition words for transition detection; resetting them
  // to zero makes a condition already true at reset count as a rising
  // change, which is wanted since the rising filters start all ones
  logic [15:0] bb_cond_prev;
  logic [15:0] dq_cond_prev;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      bb_cond_prev <= sgq_pkg::CONDITION_RST;
      dq_cond_prev <= sgq_pkg::CONDITION_RST;
    end else begin
      bb_cond_prev <= bb_cond;
      dq_cond_prev <= dq_cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode; a write aimed at a read-only or unmapped index
  // matches nothing here and is dropped without an answer, and a read
  // of any index has no side effect except on the two event latches

  logic wr_bb_rise;
  logic wr_bb_fall;
  logic wr_bb_mask;
  logic wr_dq_rise;
  logic wr_dq_fall;
  logic wr_dq_mask;
  logic rd_bb_event;
  logic rd_dq_event;

  assign wr_bb_rise = sgq_hit(i_req.wr, i_req.sel, sgq_pkg::IDX_IQ_GEN_RISING_FILTER);
  assign wr_bb_fall = sgq_hit(i_req.wr, i_req.sel, sgq_pkg::IDX_IQ_GEN_FALLING_FILTER);
  assign wr_bb_mask = sgq_hit(i_req.wr, i_req.sel, sgq_pkg::IDX_IQ_GEN_SUMMARY_MASK);
  assign wr_dq_rise = sgq_hit(i_req.wr, i_req.sel, sgq_pkg::IDX_DOUBTFUL_DATA_RISING_FILTER);
  assign wr_dq_fall = sgq_hit(i_req.wr, i_req.sel, sgq_pkg::IDX_DOUBTFUL_DATA_FALLING_FILTER);
  assign wr_dq_mask = sgq_hit(i_req.wr, i_req.sel, sgq_pkg::IDX_DOUBTFUL_DATA_SUMMARY_MASK);
  assign rd_bb_event = sgq_hit(i_req.rd, i_req.sel, sgq_pkg::IDX_IQ_GEN_EVENT_LATCH);
  assign rd_dq_event = sgq_hit(i_req.rd, i_req.sel, sgq_pkg::IDX_DOUBTFUL_DATA_EVENT_LATCH);

  ////////////////////////////////////////////////////////////////////////
  // filters and masks: the written word is the bit mask as is;
  // unused positions are stored too, so a query returns the sum as written

  logic [15:0] iq_gen_rising_filter;
  logic [15:0] iq_gen_falling_filter;
  logic [15:0] iq_gen_summary_mask;
  logic [15:0] doubtful_data_rising_filter;
  logic [15:0] doubtful_data_falling_filter;
  logic [15:0] doubtful_data_summary_mask;

  // baseband group settings
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      iq_gen_rising_filter <= sgq_pkg::RISING_FILTER_RST;
      iq_gen_falling_filter <= sgq_pkg::FALLING_FILTER_RST;
      iq_gen_summary_mask <= sgq_pkg::SUMMARY_MASK_RST;
    end else begin
      if (wr_bb_rise) begin
        iq_gen_rising_filter <= i_req.data;
      end
      if (wr_bb_fall) begin
        iq_gen_falling_filter <= i_req.data;
      end
      if (wr_bb_mask) begin
        iq_gen_summary_mask <= i_req.data;
      end
    end
  end

  // doubtful-data group settings
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      doubtful_data_rising_filter <= sgq_pkg::RISING_FILTER_RST;
      doubtful_data_falling_filter <= sgq_pkg::FALLING_FILTER_RST;
      doubtful_data_summary_mask <= sgq_pkg::SUMMARY_MASK_RST;
    end else begin
      if (wr_dq_rise) begin
        doubtful_data_rising_filter <= i_req.data;
      end
      if (wr_dq_fall) begin
        doubtful_data_falling_filter <= i_req.data;
      end
      if (wr_dq_mask) begin
        doubtful_data_summary_mask <= i_req.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event latches: a transition landing in the cycle of a clearing read
  // or clear-status survives, so no event is ever lost

  logic [15:0] iq_gen_event_latch;
  logic [15:0] doubtful_data_event_latch;
  logic [15:0] bb_new_events;
  logic [15:0] dq_new_events;
  logic [15:0] next_bb_event;
  logic [15:0] next_dq_event;

  assign bb_new_events = sgq_edges(bb_cond, bb_cond_prev, iq_gen_rising_filter,
                                   iq_gen_falling_filter);
  assign dq_new_events = sgq_edges(dq_cond, dq_cond_prev, doubtful_data_rising_filter,
                                   doubtful_data_falling_filter);

  // hold, clear on read or clear-status, then merge new events;
  // a clear and a transition in one cycle: the transition wins
  always_comb begin
    next_bb_event = iq_gen_event_latch;
    next_dq_event = doubtful_data_event_latch;
    if (rd_bb_event || i_clear_status) begin
      next_bb_event = 16'h0000;
    end
    if (rd_dq_event || i_clear_status) begin
      next_dq_event = 16'h0000;
    end
    next_bb_event = next_bb_event | bb_new_events;
    next_dq_event = next_dq_event | dq_new_events;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      iq_gen_event_latch <= sgq_pkg::EVENT_LATCH_RST;
      doubtful_data_event_latch <= sgq_pkg::EVENT_LATCH_RST;
    end else begin
      iq_gen_event_latch <= next_bb_event;
      doubtful_data_event_latch <= next_dq_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // summaries, registered from the latch state so outputs are flops;
  // this costs one cycle of lag after an event is latched;
  // a mask write likewise reaches the summary one edge after it lands

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_oper_bb_summary <= 1'h0;
      o_stb_doubtful_summary <= 1'h0;
    end else begin
      o_oper_bb_summary <= sgq_summary(iq_gen_event_latch, iq_gen_summary_mask);
      o_stb_doubtful_summary <= sgq_summary(doubtful_data_event_latch,
                                            doubtful_data_summary_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux: plain binary word, whose value equals the decimal sum of
  // the weights of its set bits; unmapped indices read zero

  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000;
    case (i_req.sel)
      sgq_pkg::IDX_IQ_GEN_CONDITION: rd_mux = bb_cond;
      sgq_pkg::IDX_IQ_GEN_RISING_FILTER: rd_mux = iq_gen_rising_filter;
      sgq_pkg::IDX_IQ_GEN_FALLING_FILTER: rd_mux = iq_gen_falling_filter;
      sgq_pkg::IDX_IQ_GEN_EVENT_LATCH: rd_mux = iq_gen_event_latch;
      sgq_pkg::IDX_IQ_GEN_SUMMARY_MASK: rd_mux = iq_gen_summary_mask;
      sgq_pkg::IDX_DOUBTFUL_DATA_CONDITION: rd_mux = dq_cond;
      sgq_pkg::IDX_DOUBTFUL_DATA_RISING_FILTER: rd_mux = doubtful_data_rising_filter;
      sgq_pkg::IDX_DOUBTFUL_DATA_FALLING_FILTER: rd_mux = doubtful_data_falling_filter;
      sgq_pkg::IDX_DOUBTFUL_DATA_EVENT_LATCH: rd_mux = doubtful_data_event_latch;
      sgq_pkg::IDX_DOUBTFUL_DATA_SUMMARY_MASK: rd_mux = doubtful_data_summary_mask;
      default: rd_mux = 16'h0000;
    endcase
  end

  // read answer one cycle after the request; with rd and wr together
  // the write lands and the answer shows the value from before it,
  // and the data holds between reads so a slow consumer may sample late
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_rd_data <= sgq_pkg::READ_DATA_RST;
      o_rd_valid <= 1'h0;
    end else begin
      o_rd_valid <= i_req.rd;
      if (i_req.rd) begin
        o_rd_data <= rd_mux;
      end
    end
  end

endmodule

`default_nettype wire

//--- sim/sgq_status_groups_checker.sv
/*
  Checker for the status bank: read timing, answer hold, reserved bits,
  mask readback and summary gating, seen at the top module's ports.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module sgq_status_groups_checker (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // register port
  input wire sgq_pkg::sgq_req_t i_req,
  input wire logic [15:0] o_rd_data,
  input wire logic o_rd_valid,
  // summary outputs
  input wire logic o_oper_bb_summary,
  input wire logic o_stb_doubtful_summary
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  ////////////////////////////////////////////////////////////////////////
  // a mask write followed at once by its query, with no write in between
  sequence mask_wr_s;
    i_req.wr && !i_req.rd && i_req.sel == sgq_pkg::IDX_IQ_GEN_SUMMARY_MASK;
  endsequence
  sequence mask_rd_s;
    i_req.rd && !i_req.wr && i_req.sel == sgq_pkg::IDX_IQ_GEN_SUMMARY_MASK;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // read answers come exactly one cycle later and then hold
  read_answer_a: assert property (i_req.rd |=> o_rd_valid)
    else $error("read request got no answer");
  stray_answer_a: assert property (!i_req.rd |=> !o_rd_valid)
    else $error("answer without a read request");
  answer_hold_a: assert property (!i_req.rd |=> $stable(o_rd_data))
    else $error("read data moved without a read");
  // reserved condition bits never show
  bb_zero_bits_a: assert property (i_req.rd && i_req.sel == sgq_pkg::IDX_IQ_GEN_CONDITION
    |=> o_rd_data[15:2] == 14'h0000) else $error("baseband reserved bit set");
  dq_zero_bits_a: assert property (i_req.rd && i_req.sel == sgq_pkg::IDX_DOUBTFUL_DATA_CONDITION
    |=> (o_rd_data & 16'hFC47) == 16'h0000) else $error("doubtful reserved bit set");
  mask_readback_a: assert property (mask_wr_s ##1 mask_rd_s |=> o_rd_data == $past(i_req.data, 2))
    else $error("mask query differs from last write");
  // a cleared mask silences the summary two edges later
  bb_mask_off_a: assert property (i_req.wr && i_req.sel == sgq_pkg::IDX_IQ_GEN_SUMMARY_MASK
    && i_req.data == 16'h0000 |-> ##2 !o_oper_bb_summary) else $error("baseband summary with empty mask");
  dq_mask_off_a: assert property (i_req.wr && i_req.sel == sgq_pkg::IDX_DOUBTFUL_DATA_SUMMARY_MASK
    && i_req.data == 16'h0000 |-> ##2 !o_stb_doubtful_summary) else $error("doubtful summary with empty mask");
  reset_quiet_a: assert property ($rose(i_rst_b) |-> !o_oper_bb_summary && !o_stb_doubtful_summary)
    else $error("summary high out of reset");
endmodule

bind sgq_status_groups sgq_status_groups_checker u_sgq_status_groups_checker (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req(i_req), .o_rd_data(o_rd_data),
  .o_rd_valid(o_rd_valid), .o_oper_bb_summary(o_oper_bb_summary),
  .o_stb_doubtful_summary(o_stb_doubtful_summary));

`default_nettype wire

//--- sim/testbench.sv
/*
  Testbench for the status bank: random status levels, filters and masks,
  a bench model of conditions and events, queued read expectations.
  Assumes the package is compiled first; the bench drives all ports.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] st_in = 8'h00;
  logic i_clear_status = 1'b0;
  sgq_pkg::sgq_req_t i_req = '0;
  logic [15:0] o_rd_data;
  logic o_rd_valid, o_oper_bb_summary, o_stb_doubtful_summary;
  logic [15:0] exp_q[$];
  logic [15:0] bb_r, bb_f, dq_r, dq_f, bbm, dqm, bb_ev, dq_ev, bb_c, dq_c, bb_n, dq_n;
  logic [31:0] rnd = 32'h13B08390;
  logic sticky = 1'b0;
  int n_errors = 0;
  int compares = 0;

  ////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  always #20 i_ref_clk = ~i_ref_clk;

  sgq_status_groups u_sgq_status_groups (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_bb_busy(st_in[0]), .i_bb_comm(st_in[1]),
    .i_power_summary(st_in[2]), .i_oven_cold(st_in[3]), .i_freq_summary(st_in[4]),
    .i_mod_summary(st_in[5]), .i_cal_summary(st_in[6]), .i_self_test_fail(st_in[7]),
    .i_clear_status(i_clear_status), .i_req(i_req), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_oper_bb_summary(o_oper_bb_summary), .o_stb_doubtful_summary(o_stb_doubtful_summary));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one request per falling edge; reads note their answer in order
  task automatic acc(input logic rd, input logic wr, input logic [3:0] sel, input logic [15:0] d,
                     input logic [15:0] e);
    @(negedge i_ref_clk);
    i_req = {rd, wr, sel, d};
    if (rd) exp_q.push_back(e);
  endtask

  task automatic idle(input int n);
    @(negedge i_ref_clk);
    i_req = '0;
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic print_verdict();
    $display("TB: errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // answer monitor: a valid with an empty queue is a stray answer;
  // sampled at the falling edge, where the registered outputs have settled
  always @(negedge i_ref_clk) begin
    if (o_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk({15'h0000, o_rd_valid}, 16'h0000);
      else chk(o_rd_data, exp_q.pop_front());
    end
  end

  // watchdog: the run needs about 800 cycles
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    {bb_f, dq_f, bbm, dqm, bb_ev, dq_ev, bb_c, dq_c} = '0;
    {bb_r, dq_r} = {2{16'hFFFF}};
    for (int k = 0; k < 10; k++) acc(1'b1, 1'b0, k[3:0], 16'h0000, (k == 1 || k == 6) ? 16'hFFFF : 16'h0000);
    for (int it = 0; it < 24; it++) begin
      rnd = xs(rnd);
      {bb_f, bb_r} = rnd;
      acc(1'b0, 1'b1, 4'h1, bb_r, 16'h0000);
      acc(1'b0, 1'b1, 4'h2, bb_f, 16'h0000);
      rnd = xs(rnd);
      {dq_f, dq_r} = rnd;
      acc(1'b0, 1'b1, 4'h6, dq_r, 16'h0000);
      acc(1'b0, 1'b1, 4'h7, dq_f, 16'h0000);
      rnd = xs(rnd);
      dqm = rnd[8] ? rnd[31:16] : 16'h0000;
      bbm = rnd[9] ? rnd[15:0] : 16'h0000;
      acc(1'b0, 1'b1, 4'h9, dqm, 16'h0000);
      acc(1'b0, 1'b1, 4'h0, rnd[31:16], 16'h0000);
      acc(1'b0, 1'b1, 4'h5, rnd[15:0], 16'h0000);
      acc(1'b0, 1'b1, 4'h4, bbm, 16'h0000);
      acc(1'b1, 1'b0, 4'h4, 16'h0000, bbm);
      acc(1'b1, 1'b0, 4'hC | {2'h0, rnd[11:10]}, 16'h0000, 16'h0000);
      idle(1);
      // new status levels; self-test failure kept rare since it sticks
      st_in = (rnd[7:0] & {&rnd[15:13], 7'h7F}) | {(it == 20), 7'h00};
      sticky = sticky | st_in[7];
      repeat (7) @(negedge i_ref_clk);
      bb_n = {14'h0000, st_in[1:0]};
      dq_n = {6'h00, sticky, st_in[6:5], 1'b0, st_in[4:2], 3'h0};
      bb_ev = bb_ev | (bb_n & ~bb_c & bb_r) | (~bb_n & bb_c & bb_f);
      dq_ev = dq_ev | (dq_n & ~dq_c & dq_r) | (~dq_n & dq_c & dq_f);
      {bb_c, dq_c} = {bb_n, dq_n};
      chk({15'h0000, o_oper_bb_summary}, {15'h0000, |(bb_ev & bbm)});
      chk({15'h0000, o_stb_doubtful_summary}, {15'h0000, |(dq_ev & dqm)});
      if (rnd[3] || it == 20) begin
        i_clear_status = 1'b1;
        @(negedge i_ref_clk);
        i_clear_status = 1'b0;
        {bb_ev, dq_ev} = '0;
      end
      acc(1'b1, 1'b0, 4'h0, 16'h0000, bb_c);
      acc(1'b1, 1'b0, 4'h5, 16'h0000, dq_c);
      acc(1'b1, 1'b0, 4'h3, 16'h0000, bb_ev);
      acc(1'b1, 1'b0, 4'h3, 16'h0000, 16'h0000);
      acc(1'b1, 1'b0, 4'h8, 16'h0000, dq_ev);
      {bb_ev, dq_ev} = '0;
      acc(1'b1, 1'b0, 4'h2, 16'h0000, bb_f);
      acc(1'b1, 1'b0, 4'h6, 16'h0000, dq_r);
      acc(1'b1, 1'b0, 4'h9, 16'h0000, dqm);
      idle(2);
    end
    idle(4);
    chk(16'(exp_q.size()), 16'h0000);
    print_verdict();
  end
endmodule

`default_nettype wire
